// file: design/uis_master.v
/*
 Single-master two-wire serial controller: start, stop, 9-clock byte
 frames, acknowledge handling, divider-derived SCL with clock sync.
 Assumes open-drain pins resolved outside with pull-ups, and a
 sequencing party that drives the plain control ports below.
*/
`timescale 1ns/1ps
`include "uis_consts.vh"

module uis_master #(
    parameter DIV_W = 8,
    parameter FILT = `UIS_FILT_CYC
) (
    // Clock and reset
    input wire clk_i,
    input wire reset_n_i,
    // Configuration
    input wire [DIV_W-1:0] baud_divider_i,
    input wire ss_event_en_i,
    input wire tx_event_en_i,
    // Requests and data
    input wire start_request_set_i,
    input wire stop_request_set_i,
    input wire load_i,
    input wire [7:0] tx_data_i,
    input wire receiving_i,
    input wire ack_level_i,
    // Status and data out
    output reg start_request_bit_o,
    output reg stop_request_bit_o,
    output reg shift_empty_flag_o,
    output reg [7:0] rx_data_o,
    output reg ack_seen_o,
    output reg busy_o,
    output wire ss_event_o,
    output wire tx_event_o,
    // Open-drain bus pins
    input wire bus_clock_pin_i,
    output wire bus_clock_pin_o,
    output wire bus_clock_pin_oe_o,
    input wire bus_data_pin_i,
    output wire bus_data_pin_o,
    output wire bus_data_pin_oe_o
);

    localparam ST_IDLE = 3'h0;
    localparam ST_START = 3'h1;
    localparam ST_WAIT = 3'h2;
    localparam ST_LOW = 3'h3;
    localparam ST_HIGH = 3'h4;
    localparam ST_STOP = 3'h5;

    reg [2:0] state;
    reg [DIV_W-1:0] div_cnt;
    reg scl_low;
    reg sda_low;
    reg [3:0] bit_cnt;
    reg [3:0] dly_cnt;
    reg [7:0] shreg;
    reg [7:0] rxreg;
    reg rcv_mode;
    reg ack_lvl;
    reg ev_ss;
    reg ev_tx;
    reg [1:0] scl_sync;
    reg [1:0] sda_sync;
    reg [3:0] filt_cnt;
    reg scl_seen;
    reg sda_prev;
    reg scl_prev;
    reg dly_run;
    reg next_sda_low;
    wire tick;
    reg [DIV_W:0] hold_cnt;
    wire hold_done;

    // Pull SDA low only for a zero bit while this side sends
    function tx_pull_low;
        input rcv;
        input msb;
        begin
            tx_pull_low = ~rcv & ~msb;
        end
    endfunction

    // Pull SDA low in the ack slot only for a chosen acknowledge
    function ack_pull_low;
        input rcv;
        input lvl;
        begin
            ack_pull_low = rcv & ~lvl;
        end
    endfunction

    // Cycles SCL has been held low by this side, saturating.
    // A byte or stop requested late must not move SDA inside the
    // low phase sooner than the SDA delay; waiting out a full
    // nominal low phase keeps the delay and the setup to SCL rise.
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hold_cnt <= {(DIV_W+1){1'b0}};
        end else if (!scl_low) begin
            hold_cnt <= {(DIV_W+1){1'b0}};
        end else if (hold_cnt != {(DIV_W+1){1'b1}}) begin
            hold_cnt <= hold_cnt + 1'b1;
        end
    end

    // Trade-off: each byte start costs up to one extra low phase
    assign hold_done = (hold_cnt > ({1'b0, baud_divider_i} + 1'b1));

    // Divider tick on undivided core clock, half SCL period each
    assign tick = (div_cnt == {DIV_W{1'b0}});

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_cnt <= {DIV_W{1'b0}};
        end else if (tick || state == ST_IDLE) begin
            div_cnt <= baud_divider_i;
        end else begin
            div_cnt <= div_cnt - 1'b1;
        end
    end

    // Two-flop pin synchronisers; pins are asynchronous to clk_i
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
        end else begin
            scl_sync <= {scl_sync[0], bus_clock_pin_i};
            sda_sync <= {sda_sync[0], bus_data_pin_i};
        end
    end

    // Noise filter: a new level, high or low alike, is accepted once it differs for FILT+1 cycles
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            filt_cnt <= 4'h0;
            scl_seen <= 1'b1;
        end else if (scl_sync[1] == scl_seen) begin
            filt_cnt <= 4'h0;
        end else if (filt_cnt == FILT[3:0]) begin
            filt_cnt <= 4'h0;
            scl_seen <= scl_sync[1];
        end else begin
            filt_cnt <= filt_cnt + 4'h1;
        end
    end

    // Stop detection: SDA rising while SCL high
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sda_prev <= 1'b1;
            scl_prev <= 1'b1;
        end else begin
            sda_prev <= sda_sync[1];
            scl_prev <= scl_sync[1];
        end
    end

    wire stop_seen = sda_sync[1] && !sda_prev && scl_sync[1] && scl_prev;

    // Main sequencer: request bits, shift path and line control.
    // Events are single-cycle pulses, gated by their enables at
    // the moment the event happens.
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= ST_IDLE;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            rxreg <= 8'h00;
            rx_data_o <= 8'h00;
            rcv_mode <= 1'b0;
            ack_lvl <= 1'b0;
            ack_seen_o <= 1'b0;
            start_request_bit_o <= 1'b0;
            stop_request_bit_o <= 1'b0;
            shift_empty_flag_o <= 1'b1;
            busy_o <= 1'b0;
            ev_ss <= 1'b0;
            ev_tx <= 1'b0;
            dly_run <= 1'b0;
            dly_cnt <= 4'h0;
            next_sda_low <= 1'b0;
        end else begin
            ev_ss <= 1'b0;
            ev_tx <= 1'b0;
            if (start_request_set_i && state == ST_IDLE) begin
                start_request_bit_o <= 1'b1;
            end
            if (stop_request_set_i) begin
                stop_request_bit_o <= 1'b1;
            end
            if (load_i) begin
                shreg <= tx_data_i;
                rcv_mode <= receiving_i;
                ack_lvl <= ack_level_i;
                shift_empty_flag_o <= 1'b0;
            end
            // Limitation: a bus stop is only reported while busy
            if (stop_seen && busy_o) begin
                busy_o <= 1'b0;
                ev_ss <= ss_event_en_i;
            end
            // Delayed SDA update after SCL fall
            if (dly_run) begin
                if (dly_cnt == `UIS_SDA_DLY) begin
                    dly_run <= 1'b0;
                    sda_low <= next_sda_low;
                end else begin
                    dly_cnt <= dly_cnt + 4'h1;
                end
            end
            case (state)
                ST_IDLE: begin
                    scl_low <= 1'b0;
                    // Start only on a free bus: both lines seen high
                    if (start_request_bit_o && scl_seen && sda_sync[1]) begin
                        state <= ST_START;
                        busy_o <= 1'b1;
                    end
                end
                ST_START: begin
                    sda_low <= 1'b1;
                    if (tick) begin
                        start_request_bit_o <= 1'b0;
                        ev_ss <= ss_event_en_i;
                        scl_low <= 1'b1;
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // Hold SCL low until a byte or stop is requested
                    // Stop has priority over a pending byte
                    if (stop_request_bit_o && !dly_run && hold_done) begin
                        sda_low <= 1'b1;
                        state <= ST_STOP;
                    end else if (!shift_empty_flag_o && !dly_run && hold_done) begin
                        // No repeated start path exists by design
                        bit_cnt <= 4'h0;
                        sda_low <= tx_pull_low(rcv_mode, shreg[7]);
                        shreg <= {shreg[6:0], 1'b0};
                        state <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    if (tick) begin
                        scl_low <= 1'b0;
                        state <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    // Phase only ends after the filtered line is high
                    if (tick && scl_seen) begin
                        scl_low <= 1'b1;
                        if (bit_cnt == `UIS_BITS - 4'h1) begin
                            ack_seen_o <= ~sda_sync[1];
                            rx_data_o <= rxreg;
                            shift_empty_flag_o <= 1'b1;
                            ev_tx <= tx_event_en_i;
                            next_sda_low <= 1'b0;
                            dly_run <= 1'b1;
                            dly_cnt <= 4'h0;
                            state <= ST_WAIT;
                        end else begin
                            rxreg <= {rxreg[6:0], sda_sync[1]};
                            bit_cnt <= bit_cnt + 4'h1;
                            if (bit_cnt == `UIS_BITS - 4'h2) begin
                                next_sda_low <= ack_pull_low(rcv_mode, ack_lvl);
                            end else begin
                                next_sda_low <= tx_pull_low(rcv_mode, shreg[7]);
                                shreg <= {shreg[6:0], 1'b0};
                            end
                            dly_run <= 1'b1;
                            dly_cnt <= 4'h0;
                            state <= ST_LOW;
                        end
                    end
                end
                ST_STOP: begin
                    // SDA stays low until SCL is seen high
                    scl_low <= 1'b0;
                    if (tick && scl_seen) begin
                        sda_low <= 1'b0;
                        stop_request_bit_o <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Only ever pull low; high comes from the pull-up
    assign bus_clock_pin_o = 1'b0;
    assign bus_clock_pin_oe_o = scl_low;
    assign bus_data_pin_o = 1'b0;
    assign bus_data_pin_oe_o = sda_low;
    assign ss_event_o = ev_ss;
    assign tx_event_o = ev_tx;

endmodule // uis_master

// file: shared/uis_consts.vh
/*
 Timing and reset constants for the single-master two-wire controller.
 Assumes inclusion by bare name from design files; definitions only.
*/
`ifndef UIS_CONSTS_VH
`define UIS_CONSTS_VH

// Core clock rate in kHz and period in ns
`define UIS_CLK_KHZ 125000
`define UIS_CLK_NS 8
// Divider reset value: 125 MHz / (2*(162+1)) ~ 383 kbps
`define UIS_DIV_RESET 8'ha2
// Noise filter width in divider-source cycles
`define UIS_FILT_CYC 2
// SDA delay after SCL fall: seven cycles minimum
`define UIS_SDA_DLY 4'h7
// Bits per byte including acknowledge slot
`define UIS_BITS 4'h9
// Address byte position of direction bit
`define UIS_DIR_BIT 0
// Direction encodings
`define UIS_DIR_WRITE 1'b0
`define UIS_DIR_READ 1'b1

`endif

// file: tb/test_uis_master.sv
/* Bench for uis_master: table of transfers, refused start, mid-run reset.
   Target model on the pulled-up lines. */
`timescale 1ns/1ps
module test_uis_master;
    logic clk_i = 1'b0, reset_n_i = 1'b0, ss_en = 1'b0, tx_en = 1'b0, st_set = 1'b0, sp_set = 1'b0;
    logic load = 1'b0, rcv = 1'b0, ackl = 1'b0;
    logic [7:0] baud = 8'h0c, tx_data = 8'h00, rx;
    logic start_bit, stop_bit, empty, ack_seen, busy, ss_ev, tx_ev, scl_oe, sda_oe, s_oe;
    logic [8:0] cap = 9'h000;
    logic [17:0] rows [3] = '{{8'h54, 8'h96, 1'b0, 1'b1}, {8'h22, 8'h3c, 1'b0, 1'b0}, {8'h55, 8'hc5, 1'b1, 1'b1}};
    int err_total = 0, total_checks = 0;
    wire scl = !scl_oe;
    wire sda = !(sda_oe || s_oe);
    always #4 clk_i = !clk_i;
    always @(posedge scl) cap <= {cap[7:0], sda};
    uis_master u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .baud_divider_i(baud), .ss_event_en_i(ss_en),
        .tx_event_en_i(tx_en), .start_request_set_i(st_set), .stop_request_set_i(sp_set), .load_i(load),
        .tx_data_i(tx_data), .receiving_i(rcv), .ack_level_i(ackl), .start_request_bit_o(start_bit),
        .stop_request_bit_o(stop_bit), .shift_empty_flag_o(empty), .rx_data_o(rx), .ack_seen_o(ack_seen),
        .busy_o(busy), .ss_event_o(ss_ev), .tx_event_o(tx_ev), .bus_clock_pin_i(scl), .bus_clock_pin_o(),
        .bus_clock_pin_oe_o(scl_oe), .bus_data_pin_i(sda), .bus_data_pin_o(), .bus_data_pin_oe_o(sda_oe));
    uis_slave_model u_slv (.scl_i(scl), .sda_i(sda), .sda_oe_o(s_oe));
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task summarize;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // k=1 start/stop event, k=0 byte event
    task wt(input bit k);
        int n;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (!(k ? ss_ev : tx_ev) && n < 4000);
        if (n >= 4000) chk(8'h00, 8'h01);
    endtask
    task req(input bit stp);
        @(negedge clk_i);
        if (stp) sp_set = 1'b1;
        else st_set = 1'b1;
        @(negedge clk_i);
        sp_set = 1'b0;
        st_set = 1'b0;
    endtask
    task ld(input logic [7:0] b, input logic r, input logic a);
        @(negedge clk_i);
        tx_data = b;
        rcv = r;
        ackl = a;
        load = 1'b1;
        @(negedge clk_i);
        load = 1'b0;
    endtask
    task go(input logic [7:0] a, input logic [7:0] d, input logic r, input logic ak, input bit poke);
        req(1'b0);
        wt(1'b1);
        chk(start_bit, 8'h00);
        chk(busy, 8'h01);
        tx_en = 1'b1;
        ld(a, 1'b0, 1'b0);
        chk(empty, 8'h00);
        if (poke) begin
            req(1'b0);
            chk(start_bit, 8'h00);
        end
        wt(1'b0);
        chk(cap[8:1], a);
        chk(ack_seen, ak);
        ld(r ? 8'hff : d, r, 1'b1);
        wt(1'b0);
        chk(empty, 8'h01);
        chk(r ? rx : cap[8:1], d);
        chk(cap[0], r | !ak);
        req(1'b1);
        wt(1'b1);
        chk(stop_bit, 8'h00);
        chk(busy, 8'h00);
    endtask
    initial begin
        repeat (16) @(negedge clk_i);
        chk({empty, scl_oe, sda_oe, busy}, 8'h08);
        reset_n_i = 1'b1;
        ss_en = 1'b1;
        foreach (rows[i]) go(rows[i][17:10], rows[i][9:2], rows[i][1], rows[i][0], i == 2);
        req(1'b0);
        wt(1'b1);
        reset_n_i = 1'b0;
        @(negedge clk_i);
        chk({empty, scl_oe, sda_oe, start_bit}, 8'h08);
        reset_n_i = 1'b1;
        go(8'h54, 8'h00, 1'b0, 1'b1, 1'b0);
        summarize;
    end
    initial begin
        #(8 * 40000);
        err_total++;
        summarize;
    end
endmodule // test_uis_master
bind uis_master uis_checker #(.DIV_W(DIV_W), .FILT(FILT)) u_chk (.*);

// file: tb/uis_checker.sv
/* Pin and event timing checks for uis_master.
   Bound onto the design top; port names match its ports. */
`timescale 1ns/1ps
module uis_checker #(parameter DIV_W = 8, parameter FILT = 2) (
    // Clock, reset, load request and divider setting
    input wire logic clk_i, reset_n_i, load_i,
    input wire logic [DIV_W-1:0] baud_divider_i,
    // Status and pins
    input wire logic start_request_bit_o, stop_request_bit_o, shift_empty_flag_o,
    input wire logic ss_event_o, tx_event_o, bus_clock_pin_o, bus_clock_pin_oe_o,
    input wire logic bus_data_pin_o, bus_data_pin_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    logic [15:0] low_n;
    logic [3:0] rise_n;
    logic scl_oe_q;
    // SCL low time, and SCL releases since the last load
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            low_n <= 16'h0000;
            rise_n <= 4'h0;
            scl_oe_q <= 1'b0;
        end else begin
            scl_oe_q <= bus_clock_pin_oe_o;
            low_n <= bus_clock_pin_oe_o ? low_n + 16'h0001 : 16'h0000;
            rise_n <= load_i ? 4'h0 : rise_n + {3'b000, scl_oe_q & ~bus_clock_pin_oe_o};
        end
    end
    sequence s_start_done; bus_data_pin_oe_o ##[0:2] ss_event_o; endsequence
    sequence s_stop_done; !bus_data_pin_oe_o && !bus_clock_pin_oe_o ##[0:8] ss_event_o; endsequence
    property p_od; bus_clock_pin_o == 1'b0 && bus_data_pin_o == 1'b0; endproperty
    property p_scl_low; $fell(bus_clock_pin_oe_o) |-> low_n >= baud_divider_i + 1; endproperty
    property p_sda_dly; $changed(bus_data_pin_oe_o) && $past(bus_clock_pin_oe_o) && bus_clock_pin_oe_o
        |-> low_n == 7 || low_n == 8 || low_n > baud_divider_i + 1; endproperty
    property p_start; $rose(bus_data_pin_oe_o) && !bus_clock_pin_oe_o |-> start_request_bit_o; endproperty
    property p_stop; $fell(bus_data_pin_oe_o) && !bus_clock_pin_oe_o
        |-> stop_request_bit_o || $past(stop_request_bit_o); endproperty
    property p_start_clr; $fell(start_request_bit_o) |-> s_start_done; endproperty
    property p_stop_clr; $fell(stop_request_bit_o) |-> s_stop_done; endproperty
    property p_tx_evt; tx_event_o |-> shift_empty_flag_o && rise_n == 4'h9 && bus_clock_pin_oe_o; endproperty
    a_od: assert property (p_od) else $error("bus pin driven high");
    a_scl_low: assert property (p_scl_low) else $error("SCL low phase short");
    a_sda_dly: assert property (p_sda_dly) else $error("SDA delay wrong");
    a_start: assert property (p_start) else $error("start not requested");
    a_stop: assert property (p_stop) else $error("stop not requested");
    a_start_clr: assert property (p_start_clr) else $error("start done wrong");
    a_stop_clr: assert property (p_stop_clr) else $error("stop done wrong");
    a_tx_evt: assert property (p_tx_evt) else $error("byte event misplaced");
endmodule // uis_checker

// file: tb/uis_slave_model.sv
/* Two-wire target: 7-bit address match, acks writes, returns a fixed byte.
   Lines resolved outside with pull-ups. */
`timescale 1ns/1ps
module uis_slave_model #(parameter [6:0] ADDR = 7'h2a, parameter [7:0] RDATA = 8'hc5) (
    // Bus lines and data pull-down
    input wire scl_i,
    input wire sda_i,
    output reg sda_oe_o
);
    reg [3:0] bit_n = 4'h0;
    reg [7:0] sh = 8'h00;
    reg first = 1'b0;
    reg sel = 1'b0;
    reg rd = 1'b0;
    initial sda_oe_o = 1'b0;
    always @(negedge sda_i) if (scl_i) begin
        bit_n = 4'h0;
        first = 1'b1;
        sel = 1'b0;
    end
    always @(posedge scl_i) begin
        bit_n = bit_n + 4'h1;
        sh = {sh[6:0], sda_i};
    end
    // Zero hold: changes right at the SCL fall
    always @(negedge scl_i) begin
        if (bit_n == 4'h8 && first) begin
            sel = sh[7:1] == ADDR;
            rd = sh[0];
        end
        if (bit_n == 4'h9) begin
            bit_n = 4'h0;
            first = 1'b0;
        end
        if (bit_n == 4'h8)
            sda_oe_o = sel && (first || !rd);
        else if (sel && rd && !first && !(bit_n == 4'h0 && sh[0]))
            sda_oe_o = !RDATA[3'h7 - bit_n[2:0]];
        else
            sda_oe_o = 1'b0;
    end
endmodule // uis_slave_model
